// File: include/charger_pkg.sv
// constants shared by the charger control and status logic
package charger_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	// register offsets
	localparam logic [7:0] OFS_INPUT_CURRENT_LIMIT = 8'h00;
	localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h03;
	localparam logic [7:0] OFS_STATUS = 8'h0b;
	// field positions
	localparam int unsigned BIT_BOOST_EN = 5;
	localparam int unsigned BIT_CHARGE_EN = 4;
	localparam int unsigned BIT_INPUT_LIMIT_PIN_ENABLE = 6;
	localparam int unsigned BIT_STATUS_PIN_DISABLE = 6;
	// reset values
	localparam logic [7:0] RST_INPUT_CURRENT_LIMIT = 8'h48;
	localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h1a;
	// system voltage floor and thermal threshold codes
	localparam logic [7:0] MIN_SYS_MV_DEFAULT = 8'h23;
	localparam logic [7:0] THERMAL_C_DEFAULT = 8'h78;
	// timing
	localparam int unsigned INT_PULSE_US = 256;
	localparam int unsigned INT_PULSE_CYCLES = INT_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLINK_HZ = 1;
	localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
	// charge phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_PRE = 3'b001,
		PH_CC = 3'b011,
		PH_CV = 3'b010,
		PH_DONE = 3'b110
	} phase_t;
	// input source classes
	typedef enum logic [1:0] {
		SRC_SDP = 2'h0,
		SRC_CDP = 2'h1,
		SRC_DCP = 2'h2,
		SRC_ADAPTER = 2'h3
	} source_t;
endpackage

// File: hdl/pulse_timer.sv
// one-shot low pulse timer that ignores triggers while running
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
	parameter int unsigned CYCLES = 12800
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// trigger and pulse
	input wire logic i_trigger,
	output logic o_active
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_r;

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			count_r <= '0;
		else if (count_r != '0)
			count_r <= count_r - 1'b1;
		else if (i_trigger)
			count_r <= CW'(CYCLES);
	end

	assign o_active = (count_r != '0);

	a_pulse_width: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(o_active) |-> o_active [*8]) else $error("pulse too short");
	a_no_retrigger: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_active && i_trigger && (count_r > CW'(1)) |=> (count_r < $past(count_r)))
		else $error("pulse retriggered");
	c_pulse_seen: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $fell(o_active));
endmodule
`default_nettype wire

// File: hdl/charger_control.sv
// control and status sequencer of the single-cell charger
// How it works
// - status pin low while charging, else released
// - any fault makes status pin blink 1 Hz
// - status-pin-disable bit releases the status pin
// - status change or fault gives 256 us alert
// - boost needs control bit 5 and pin high
// - charging needs control bit 4 and pin low
// - input limit is smaller of pin and register
// - pin enable bit 6 clear uses register limit only
// - autonomous precondition, constant current, constant voltage phases
// - terminate in constant voltage below termination current
// - recharge when full battery falls below threshold
// - input limit reached cuts charge current first
// - load past zero charge enters supplement mode
// - system floor above battery, default minimum
// - over thermal threshold reduces charge current
// - classify source from data-line detection result
`timescale 1ns/1ps
`default_nettype none
module charger_control #(
	parameter int unsigned INT_CYCLES = charger_pkg::INT_PULSE_CYCLES,
	parameter int unsigned BLINK_HALF = charger_pkg::BLINK_HALF_CYCLES,
	parameter int unsigned LIM_W = 6
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// control pins
	input wire logic i_boost_enable_pin,
	input wire logic i_charge_enable_n,
	input wire logic [LIM_W-1:0] i_input_limit_resistor_pin,
	// analog comparator results
	input wire logic i_bat_below_pre,
	input wire logic i_bat_below_cv,
	input wire logic i_bat_below_recharge,
	input wire logic i_chg_below_term,
	input wire logic i_input_limit_hit,
	input wire logic i_sys_load_rising,
	input wire logic i_over_thermal,
	input wire logic i_fault,
	input wire logic [1:0] i_detect_result,
	input wire logic [7:0] i_min_sys_code,
	input wire logic [7:0] i_thermal_code,
	// regulation controls
	output logic o_boost_en,
	output logic o_charge_en,
	output logic [LIM_W-1:0] o_input_limit,
	output logic o_charge_reduce,
	output logic o_charge_zero,
	output logic o_supplement,
	output logic [7:0] o_min_sys_target,
	output logic [7:0] o_thermal_target,
	output logic [2:0] o_phase,
	output logic [1:0] o_source,
	// open-drain status and alert
	output logic o_stat_out,
	output logic o_stat_oe,
	output logic o_int_out,
	output logic o_int_oe
);
	logic [7:0] lim_reg_r;
	logic [7:0] sysctl_reg_r;
	charger_pkg::phase_t phase_r;
	charger_pkg::phase_t phase_nxt;
	charger_pkg::source_t source_r;
	logic [LIM_W-1:0] limit_r;
	logic boost_r;
	logic charge_r;
	logic reduce_r;
	logic zero_r;
	logic supp_r;
	logic [7:0] minsys_r;
	logic [7:0] therm_r;
	logic [31:0] blink_cnt_r;
	logic blink_r;
	logic charging_prev_r;
	logic fault_prev_r;
	logic [7:0] rdata_r;
	logic charging;
	logic int_trigger;
	logic int_active;
	logic charge_allowed;

	// registers
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			lim_reg_r <= charger_pkg::RST_INPUT_CURRENT_LIMIT;
			sysctl_reg_r <= charger_pkg::RST_SYSTEM_CONTROL;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == charger_pkg::OFS_INPUT_CURRENT_LIMIT)
				lim_reg_r <= i_reg_wdata;
			else if (i_reg_addr == charger_pkg::OFS_SYSTEM_CONTROL)
				sysctl_reg_r <= i_reg_wdata;
		end
	end

	// read data, unmapped reads zero
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rdata_r <= 8'h00;
		else if (i_reg_rd)
		begin
			if (i_reg_addr == charger_pkg::OFS_INPUT_CURRENT_LIMIT)
				rdata_r <= lim_reg_r;
			else if (i_reg_addr == charger_pkg::OFS_SYSTEM_CONTROL)
				rdata_r <= sysctl_reg_r;
			else if (i_reg_addr == charger_pkg::OFS_STATUS)
				rdata_r <= {source_r, i_fault, supp_r, zero_r, 3'(phase_r)};
			else
				rdata_r <= 8'h00;
		end
	end
	assign o_reg_rdata = rdata_r;

	// enables; the charge pin is trusted to be driven, never floating
	assign charge_allowed = sysctl_reg_r[charger_pkg::BIT_CHARGE_EN] && !i_charge_enable_n;
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			boost_r <= 1'b0;
			charge_r <= 1'b0;
		end
		else
		begin
			boost_r <= sysctl_reg_r[charger_pkg::BIT_BOOST_EN] && i_boost_enable_pin;
			charge_r <= charge_allowed && (phase_r != charger_pkg::PH_DONE);
		end
	end

	// effective input limit
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			limit_r <= '0;
		else if (!lim_reg_r[charger_pkg::BIT_INPUT_LIMIT_PIN_ENABLE])
			limit_r <= lim_reg_r[LIM_W-1:0];
		else if (i_input_limit_resistor_pin < lim_reg_r[LIM_W-1:0])
			limit_r <= i_input_limit_resistor_pin;
		else
			limit_r <= lim_reg_r[LIM_W-1:0];
	end

	// charge phase sequencing
	always_comb
	begin
		phase_nxt = phase_r;
		case (phase_r)
			charger_pkg::PH_IDLE:
				phase_nxt = charger_pkg::PH_PRE;
			charger_pkg::PH_PRE:
				if (!i_bat_below_pre)
					phase_nxt = charger_pkg::PH_CC;
			charger_pkg::PH_CC:
				if (i_bat_below_pre)
					phase_nxt = charger_pkg::PH_PRE;
				else if (!i_bat_below_cv)
					phase_nxt = charger_pkg::PH_CV;
			charger_pkg::PH_CV:
				if (i_chg_below_term)
					phase_nxt = charger_pkg::PH_DONE;
			charger_pkg::PH_DONE:
				if (i_bat_below_recharge)
					phase_nxt = charger_pkg::PH_PRE;
			default:
				phase_nxt = charger_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			phase_r <= charger_pkg::PH_IDLE;
		else if (!charge_allowed)
			phase_r <= charger_pkg::PH_IDLE;
		else
			phase_r <= phase_nxt;
	end

	// power path priority: charge current goes first, battery only after
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			reduce_r <= 1'b0;
			zero_r <= 1'b0;
			supp_r <= 1'b0;
		end
		else
		begin
			reduce_r <= i_input_limit_hit || i_over_thermal;
			zero_r <= i_input_limit_hit && (reduce_r || zero_r);
			supp_r <= i_input_limit_hit && zero_r && (i_sys_load_rising || supp_r);
		end
	end

	// regulation targets; zero code keeps the defaults
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			minsys_r <= charger_pkg::MIN_SYS_MV_DEFAULT;
			therm_r <= charger_pkg::THERMAL_C_DEFAULT;
		end
		else
		begin
			minsys_r <= (i_min_sys_code == 8'h00) ? charger_pkg::MIN_SYS_MV_DEFAULT : i_min_sys_code;
			therm_r <= (i_thermal_code == 8'h00) ? charger_pkg::THERMAL_C_DEFAULT : i_thermal_code;
		end
	end

	// source classification
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			source_r <= charger_pkg::SRC_SDP;
		else
			source_r <= charger_pkg::source_t'(i_detect_result);
	end

	// blink divider, free running so halves stay equal
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			blink_cnt_r <= 32'h0;
			blink_r <= 1'b0;
		end
		else if (blink_cnt_r >= 32'(BLINK_HALF - 1))
		begin
			blink_cnt_r <= 32'h0;
			blink_r <= ~blink_r;
		end
		else
			blink_cnt_r <= blink_cnt_r + 32'h1;
	end

	// status pin: low pulls the line, release lets it float high
	assign charging = charge_r && (phase_r != charger_pkg::PH_IDLE);
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_stat_oe <= 1'b0;
		else if (sysctl_reg_r[charger_pkg::BIT_STATUS_PIN_DISABLE])
			o_stat_oe <= 1'b0;
		else if (i_fault)
			o_stat_oe <= blink_r;
		else
			o_stat_oe <= charging;
	end
	assign o_stat_out = 1'b0;

	// alert on status change or fault
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			charging_prev_r <= 1'b0;
			fault_prev_r <= 1'b0;
		end
		else
		begin
			charging_prev_r <= charging;
			fault_prev_r <= i_fault;
		end
	end
	assign int_trigger = (charging != charging_prev_r) || (i_fault && !fault_prev_r);

	pulse_timer #(
		.CYCLES(INT_CYCLES)
	) u_int_timer (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_trigger(int_trigger),
		.o_active(int_active)
	);
	assign o_int_out = 1'b0;
	assign o_int_oe = int_active;

	assign o_boost_en = boost_r;
	assign o_charge_en = charge_r;
	assign o_input_limit = limit_r;
	assign o_charge_reduce = reduce_r;
	assign o_charge_zero = zero_r;
	assign o_supplement = supp_r;
	assign o_min_sys_target = minsys_r;
	assign o_thermal_target = therm_r;
	assign o_phase = 3'(phase_r);
	assign o_source = 2'(source_r);

	a_boost_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_boost_en |-> $past(sysctl_reg_r[charger_pkg::BIT_BOOST_EN] && i_boost_enable_pin))
		else $error("boost without both enables");
	a_charge_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_charge_en |-> $past(charge_allowed)) else $error("charge without both enables");
	a_limit_min: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		##1 (o_input_limit <= $past(lim_reg_r[LIM_W-1:0]))) else $error("limit above register");
	a_limit_nopin: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!lim_reg_r[charger_pkg::BIT_INPUT_LIMIT_PIN_ENABLE] ##1
		!$past(lim_reg_r[charger_pkg::BIT_INPUT_LIMIT_PIN_ENABLE]) |->
		o_input_limit == $past(lim_reg_r[LIM_W-1:0])) else $error("pin limit used");
	a_term_cv: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		phase_r == charger_pkg::PH_CV && i_chg_below_term && charge_allowed |=>
		phase_r == charger_pkg::PH_DONE) else $error("no termination");
	a_recharge_go: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		phase_r == charger_pkg::PH_DONE && i_bat_below_recharge && charge_allowed |=>
		phase_r == charger_pkg::PH_PRE) else $error("no recharge");
	a_supp_order: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(o_supplement) |-> $past(o_charge_zero)) else $error("supplement before zero");
	a_stat_disable: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		sysctl_reg_r[charger_pkg::BIT_STATUS_PIN_DISABLE] |=> !o_stat_oe)
		else $error("status pin driven while disabled");
	a_stat_charge: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!sysctl_reg_r[charger_pkg::BIT_STATUS_PIN_DISABLE] && !i_fault |=> o_stat_oe == $past(charging))
		else $error("status pin wrong level");
	a_int_fault: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		int_trigger && !int_active |=> o_int_oe) else $error("alert missing");
	c_full_cycle: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		phase_r == charger_pkg::PH_CV ##1 phase_r == charger_pkg::PH_DONE);
	c_recharge: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		phase_r == charger_pkg::PH_DONE ##1 phase_r == charger_pkg::PH_PRE);
	c_supplement: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $rose(o_supplement));
	c_blink: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) i_fault && $rose(o_stat_oe));
endmodule
`default_nettype wire

// File: verification/charger_host_model.sv
// host side model: register access, enable pins, pulled-up open-drain lines
`timescale 1ns/1ps
`default_nettype none
module charger_host_model (
	// clock
	input wire logic i_ref_clk,
	// register port
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	input wire logic [7:0] i_reg_rdata,
	// pins
	output logic o_boost_enable_pin,
	output logic o_charge_enable_n,
	input wire logic i_stat_oe,
	input wire logic i_int_oe,
	output logic o_stat_level,
	output logic o_int_level
);
	// pull-ups hold both lines high unless the device sinks them
	assign o_stat_level = !i_stat_oe;
	assign o_int_level = !i_int_oe;
	initial
	begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_boost_enable_pin = 1'b0;
		o_charge_enable_n = 1'b1;
	end
	// pin never left floating
	task automatic set_pins(input logic b, input logic c);
		o_boost_enable_pin <= b;
		o_charge_enable_n <= c;
	endtask
	// idle address and data scrambled so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_reg_wr <= 1'b1;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_ref_clk);
		o_reg_wr <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_reg_rd <= 1'b1;
		o_reg_addr <= a;
		@(posedge i_ref_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		@(posedge i_ref_clk);
		d = i_reg_rdata;
	endtask
endmodule
`default_nettype wire

// File: verification/charger_control_status_logic_bench.sv
// self-checking bench of the charger control and status logic
`timescale 1ns/1ps
`default_nettype none
module charger_control_status_logic_bench;
	typedef struct packed {
		logic [7:0] r0;
		logic [7:0] r3;
		logic bp;
		logic cen;
		logic [5:0] pin;
		logic [7:0] msys;
		logic [1:0] det;
		logic eb;
		logic ec;
		logic [5:0] lim;
		logic [7:0] emsys;
	} row_t;
	row_t rows [4] = '{
		'{8'h48, 8'h30, 1'b1, 1'b0, 6'h05, 8'h00, 2'h0, 1'b1, 1'b1, 6'h05, 8'h23},
		'{8'h48, 8'h30, 1'b0, 1'b1, 6'h3f, 8'h28, 2'h1, 1'b0, 1'b0, 6'h08, 8'h28},
		'{8'h08, 8'h10, 1'b1, 1'b0, 6'h02, 8'h00, 2'h2, 1'b0, 1'b1, 6'h08, 8'h23},
		'{8'h7f, 8'h20, 1'b1, 1'b1, 6'h3f, 8'h32, 2'h3, 1'b1, 1'b0, 6'h3f, 8'h32}};
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic pre = 1'b0, cv = 1'b0, rech = 1'b0, term = 1'b0, hit = 1'b0;
	logic load = 1'b0, therm = 1'b0, fault = 1'b0;
	logic [1:0] det = 2'h0;
	logic [7:0] msys = 8'h00, tcode = 8'h00, d;
	logic [5:0] res = 6'h3f;
	wire logic wr, rd, bpin, cen, stat_oe, int_oe, stat_lvl, stat_out, int_out;
	wire logic [7:0] addr, wdata, rdata, min_sys, therm_t;
	wire logic boost_en, charge_en, reduce, zero, supp;
	wire logic [5:0] lim;
	wire logic [2:0] phase;
	wire logic [1:0] src;
	int num_errors = 0;
	int checks = 0;
	int n, ns;
	always #10 ref_clk = ~ref_clk;
	charger_control #(.INT_CYCLES(16), .BLINK_HALF(8)) u_charger_control (
		.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_boost_enable_pin(bpin), .i_charge_enable_n(cen),
		.i_input_limit_resistor_pin(res), .i_bat_below_pre(pre), .i_bat_below_cv(cv),
		.i_bat_below_recharge(rech), .i_chg_below_term(term), .i_input_limit_hit(hit),
		.i_sys_load_rising(load), .i_over_thermal(therm), .i_fault(fault),
		.i_detect_result(det), .i_min_sys_code(msys), .i_thermal_code(tcode),
		.o_boost_en(boost_en), .o_charge_en(charge_en), .o_input_limit(lim),
		.o_charge_reduce(reduce), .o_charge_zero(zero), .o_supplement(supp),
		.o_min_sys_target(min_sys), .o_thermal_target(therm_t), .o_phase(phase),
		.o_source(src), .o_stat_out(stat_out), .o_stat_oe(stat_oe), .o_int_out(int_out),
		.o_int_oe(int_oe));
	charger_host_model u_charger_host_model (
		.i_ref_clk(ref_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
		.o_reg_wdata(wdata), .i_reg_rdata(rdata), .o_boost_enable_pin(bpin),
		.o_charge_enable_n(cen), .i_stat_oe(stat_oe), .i_int_oe(int_oe),
		.o_stat_level(stat_lvl), .o_int_level());
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// bounded wait for a phase, then compare it
	task automatic wait_phase(input logic [2:0] p);
		int k;
		k = 0;
		while (phase !== p && k < 50)
		begin
			@(posedge ref_clk);
			k++;
		end
		check(phase, p);
		if (k >= 50)
			tally_and_finish();
	endtask
	// driven cycles of both open-drain lines over a window
	task automatic count_high(input int len, output int cs, output int ci);
		cs = 0;
		ci = 0;
		repeat (len)
		begin
			@(posedge ref_clk);
			if (stat_oe === 1'b1)
				cs++;
			if (int_oe === 1'b1)
				ci++;
		end
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		check(min_sys, 8'h23);
		check(therm_t, 8'h78);
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			u_charger_host_model.set_pins(rows[i].bp, rows[i].cen);
			u_charger_host_model.wr(8'h00, rows[i].r0);
			u_charger_host_model.wr(8'h03, rows[i].r3);
			msys <= rows[i].msys;
			det <= rows[i].det;
			res <= rows[i].pin;
			repeat (5) @(posedge ref_clk);
			check(boost_en, rows[i].eb);
			check(charge_en, rows[i].ec);
			check(lim, rows[i].lim);
			check(min_sys, rows[i].emsys);
			check(src, rows[i].det);
			$display("row %0d done", i);
		end
		// let any alert from the last row expire first
		repeat (20) @(posedge ref_clk);
		pre <= 1'b1;
		cv <= 1'b1;
		u_charger_host_model.set_pins(1'b0, 1'b0);
		u_charger_host_model.wr(8'h03, 8'h10);
		// a fault edge inside the running pulse must not stretch it
		fork
			count_high(40, ns, n);
			begin
				repeat (6) @(posedge ref_clk);
				fault <= 1'b1;
				repeat (2) @(posedge ref_clk);
				fault <= 1'b0;
			end
		join
		check(n, 8'h10);
		wait_phase(3'h1);
		check(stat_lvl, 1'b0);
		pre <= 1'b0;
		wait_phase(3'h3);
		cv <= 1'b0;
		wait_phase(3'h2);
		term <= 1'b1;
		wait_phase(3'h6);
		repeat (2) @(posedge ref_clk);
		check(stat_lvl, 1'b1);
		term <= 1'b0;
		cv <= 1'b1;
		rech <= 1'b1;
		wait_phase(3'h3);
		rech <= 1'b0;
		$display("charge cycle test done");
		fault <= 1'b1;
		repeat (3) @(posedge ref_clk);
		count_high(32, n, ns);
		check(n, 8'h10);
		check(stat_out, 1'b0);
		check(int_out, 1'b0);
		u_charger_host_model.wr(8'h03, 8'h50);
		repeat (2) @(posedge ref_clk);
		count_high(32, n, ns);
		check(n, 8'h00);
		fault <= 1'b0;
		u_charger_host_model.wr(8'h03, 8'h10);
		$display("status pin test done");
		hit <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check(zero, 1'b1);
		check(supp, 1'b0);
		load <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check(supp, 1'b1);
		hit <= 1'b0;
		load <= 1'b0;
		therm <= 1'b1;
		tcode <= 8'h64;
		repeat (4) @(posedge ref_clk);
		check(reduce, 1'b1);
		check(therm_t, 8'h64);
		$display("regulation test done");
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(charge_en, 1'b0);
		check(int_oe, 1'b0);
		reset_n <= 1'b1;
		u_charger_host_model.wr(8'h22, 8'hff);
		u_charger_host_model.rd(8'h00, d);
		check(d, 8'h48);
		u_charger_host_model.rd(8'h03, d);
		check(d, 8'h1a);
		u_charger_host_model.rd(8'h22, d);
		check(d, 8'h00);
		// adapter source, constant current phase, no fault or supplement
		u_charger_host_model.rd(8'h0b, d);
		check(d, 8'hc3);
		$display("register test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
